// [design/gcl_port_lock.sv]
// How it works
// - Key bit 16 sets only after write 1, write 0, write 1, then read returning 0.
// - Once set, key bit stays 1 until system reset; software cannot clear it.
// - Lock mask bits 15:0 are writable only while the key bit is 0.
// - Sequence is valid only if mask stays unchanged across all its accesses.
// - With key bit 0, every pin's mode bits and the alternate bits of pins 0-7 are writable.
// - With key bit 1, pins whose mask bit is 1 are frozen; others stay writable.
// - When USB is enabled, the two USB data pins bypass port configuration.
// - Each port instance decodes its own base, first lowest, later ones 0x400 apart.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "gcl_consts.svh"
module gcl_port_lock #(
  parameter int PINS = 16,
  parameter int PORT_INDEX = 0,
  parameter int USB_MINUS_PIN = 11,
  parameter int USB_PLUS_PIN = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port, full words only
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  // USB function enable from the USB block, same clock
  input wire logic usbEnable,
  // Configuration seen by the pads
  output logic [2*PINS-1:0] pinModeOut,
  output logic [4*PINS-1:0] altFuncOut,
  output logic [1:0] usbRouted,
  output logic lockKeyOut
);
  localparam logic [31:0] PORT_BASE = `GCL_FIRST_PORT_BASE + 32'(PORT_INDEX) * `GCL_PORT_STEP;
  localparam int KEY = `GCL_LOCK_KEY_POS;

  logic [2*PINS-1:0] pinMode;
  logic [4*PINS-1:0] altFunc;
  logic [PINS-1:0] pinLockMask, next_pinLockMask;
  logic lockKeyBit, next_lockKeyBit;
  logic [PINS-1:0] seqMask, next_seqMask;
  gcl_pkg::gcl_key_e keyState, next_keyState;
  logic [31:0] next_rdData;
  logic [2*PINS-1:0] next_pinModeOut;
  logic [4*PINS-1:0] next_altFuncOut;
  logic [1:0] next_usbRouted;
  logic [PINS-1:0] frozen;
  logic hitPort, selMode, selLock, selAlt;
  logic wrMode, wrAlt, wrLock, rdLock;
  logic [PINS-1:0] wrMask;
  logic wrKey;
  logic maskSame;

  // Port decode on the upper address bits. The register offset sits in the
  // low ten bits only: bits 11:10 already belong to the port base and change
  // from one port to the next, so comparing them against the offset would
  // make the first port unreachable.
  always_comb begin
    hitPort = (addr[31:10] == PORT_BASE[31:10]);
    selMode = hitPort && (addr[9:0] == 10'(`GCL_OFS_PIN_MODE));
    selLock = hitPort && (addr[9:0] == 10'(`GCL_OFS_CONFIG_LOCK));
    selAlt = hitPort && (addr[9:0] == 10'(`GCL_OFS_ALT_FUNC));
  end

  // Strobe qualification; an access to a foreign address is dropped silently
  always_comb begin
    wrMode = wrStb && selMode;
    wrAlt = wrStb && selAlt;
    wrLock = wrStb && selLock;
    rdLock = rdStb && selLock;
  end

  // Lock register fields as carried on the write data.
  // The mask comparison is against the mask captured at the first step,
  // so a mask that wanders and comes back still counts as a change.
  always_comb begin
    wrMask = wrData[PINS-1:0];
    wrKey = wrData[KEY];
    maskSame = (wrMask == seqMask);
  end

  // Freeze only where both key and mask bit are 1; one flag per pin.
  // Until the key arms, the mask is only a proposal and freezes nothing.
  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_freeze
      assign frozen[p] = lockKeyBit && pinLockMask[p];
    end
  endgenerate

  gcl_port_regs #(
    .PINS(PINS),
    .FW(2),
    .RST(`GCL_PIN_MODE_RST)
  ) modeRegs (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrEn(wrMode),
    .wrData(wrData[2*PINS-1:0]),
    .pinFrozen(frozen),
    .value(pinMode)
  );

  // Four alternate-function bits per pin span two words; low eight pins here.
  // The upper word is fed back unchanged, so a write never disturbs pins 8-15.
  logic [4*PINS-1:0] altWrData;
  always_comb begin
    altWrData = altFunc;
    altWrData[31:0] = wrData;
  end

  gcl_port_regs #(
    .PINS(PINS),
    .FW(4),
    .RST(`GCL_ALT_FUNC_RST)
  ) altRegs (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrEn(wrAlt),
    .wrData(altWrData),
    .pinFrozen(frozen),
    .value(altFunc)
  );

  // Key sequence tracker and lock mask.
  // The tracker sleeps once the key is armed: nothing short of a reset may
  // move it again, which keeps a stray sequence from touching the mask.
  always_comb begin
    next_keyState = keyState;
    next_seqMask = seqMask;
    next_lockKeyBit = lockKeyBit;
    next_pinLockMask = pinLockMask;
    if (wrLock && !lockKeyBit) begin
      next_pinLockMask = wrMask;
    end
    if (!lockKeyBit) begin
      case (keyState)
        // Waiting for the opening write of 1
        gcl_pkg::GCL_KEY_IDLE: begin
          if (wrLock && wrKey) begin
            next_keyState = gcl_pkg::GCL_KEY_W1;
            next_seqMask = wrMask;
          end
        end
        // Opening write seen; a write of 0 with the same mask must follow
        gcl_pkg::GCL_KEY_W1: begin
          if (wrLock) begin
            if (!wrKey && maskSame) begin
              next_keyState = gcl_pkg::GCL_KEY_W0;
            end else if (wrKey) begin
              // A fresh write of 1 counts as a new first step
              next_keyState = gcl_pkg::GCL_KEY_W1;
              next_seqMask = wrMask;
            end else begin
              next_keyState = gcl_pkg::GCL_KEY_IDLE;
            end
          end else if (rdLock) begin
            next_keyState = gcl_pkg::GCL_KEY_IDLE;
          end
        end
        // Write of 0 seen; the closing write of 1 must follow
        gcl_pkg::GCL_KEY_W0: begin
          if (wrLock && wrKey && maskSame) begin
            next_keyState = gcl_pkg::GCL_KEY_W1B;
          end else if (wrLock || rdLock) begin
            next_keyState = gcl_pkg::GCL_KEY_IDLE;
          end
        end
        // All writes seen; only a read of the lock register completes it
        gcl_pkg::GCL_KEY_W1B: begin
          if (rdLock) begin
            // Read returns 0 in the key bit, then the key arms
            next_lockKeyBit = 1'b1;
            next_keyState = gcl_pkg::GCL_KEY_IDLE;
          end else if (wrLock) begin
            next_keyState = gcl_pkg::GCL_KEY_IDLE;
          end
        end
        default: begin
          next_keyState = gcl_pkg::GCL_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      keyState <= gcl_pkg::GCL_KEY_IDLE;
      seqMask <= '0;
      lockKeyBit <= 1'b0;
      pinLockMask <= '0;
    end else begin
      keyState <= next_keyState;
      seqMask <= next_seqMask;
      lockKeyBit <= next_lockKeyBit;
      pinLockMask <= next_pinLockMask;
    end
  end

  // Read data: the lock read returns the key as it stood before this access,
  // which is why the completing read of the sequence still shows 0.
  // Reads of other offsets or other ports return zero.
  always_comb begin
    next_rdData = 32'h0000_0000;
    if (rdStb) begin
      if (selMode) begin
        next_rdData[2*PINS-1:0] = pinMode;
      end else if (selAlt) begin
        next_rdData = altFunc[31:0];
      end else if (selLock) begin
        next_rdData[PINS-1:0] = pinLockMask;
        next_rdData[KEY] = lockKeyBit;
      end
    end
  end

  // USB pins are handed to the transceiver regardless of their mode bits.
  // The mode register itself keeps its value, so software sees no change
  // and the pins fall back to their own setting when USB is disabled.
  always_comb begin
    next_pinModeOut = pinMode;
    next_altFuncOut = altFunc;
    next_usbRouted = {usbEnable, usbEnable};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h0000_0000;
      pinModeOut <= `GCL_PIN_MODE_RST;
      altFuncOut <= '0;
      usbRouted <= 2'h0;
      lockKeyOut <= 1'b0;
    end else begin
      rdData <= next_rdData;
      pinModeOut <= next_pinModeOut;
      altFuncOut <= next_altFuncOut;
      usbRouted <= next_usbRouted;
      lockKeyOut <= next_lockKeyBit;
    end
  end
endmodule
`default_nettype wire

// [inc/gcl_consts.svh]
`ifndef GCL_CONSTS_SVH
`define GCL_CONSTS_SVH
// Register byte offsets within one port
`define GCL_OFS_PIN_MODE 12'h000
`define GCL_OFS_CONFIG_LOCK 12'h01C
`define GCL_OFS_ALT_FUNC 12'h020
// Port decode: first port base, step between ports
`define GCL_FIRST_PORT_BASE 32'h4001_0800
`define GCL_PORT_STEP 32'h0000_0400
// Lock register fields
`define GCL_LOCK_KEY_POS 16
`define GCL_LOCK_MASK_W 16
// Reset values
`define GCL_PIN_MODE_RST 32'hFFFF_FFFF
`define GCL_ALT_FUNC_RST 32'h0000_0000
`define GCL_LOCK_RST 32'h0000_0000
`endif

// [inc/gcl_pkg.sv]
package gcl_pkg;
  typedef enum logic [1:0] {
    GCL_KEY_IDLE = 2'b00,
    GCL_KEY_W1 = 2'b01,
    GCL_KEY_W0 = 2'b10,
    GCL_KEY_W1B = 2'b11
  } gcl_key_e;
endpackage

// [design/gcl_port_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gcl_consts.svh"
// Per-pin configuration storage with lock-gated writes and registered contents
module gcl_port_regs #(
  parameter int PINS = 16,
  parameter int FW = 2,
  parameter logic [31:0] RST = 32'h0000_0000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write side
  input wire logic wrEn,
  input wire logic [PINS*FW-1:0] wrData,
  input wire logic [PINS-1:0] pinFrozen,
  // Contents
  output logic [PINS*FW-1:0] value
);
  logic [PINS*FW-1:0] next_value;

  always_comb begin
    next_value = value;
    for (int i = 0; i < PINS; i++) begin
      if (wrEn && !pinFrozen[i]) begin
        next_value[i*FW +: FW] = wrData[i*FW +: FW];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // RST is one word; wider fields get zero-filled above it
      value <= (PINS*FW)'(RST);
    end else begin
      value <= next_value;
    end
  end
endmodule
`default_nettype wire

// [testbench/gcl_lock_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module gcl_lock_monitor #(
  parameter int PINS = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [31:0] rdData,
  // Pad side
  input wire logic usbEnable,
  input wire logic [2*PINS-1:0] pinModeOut,
  input wire logic [4*PINS-1:0] altFuncOut,
  input wire logic [1:0] usbRouted,
  input wire logic lockKeyOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic lk;
  assign lk = addr == 32'h4001_081C;
  sequence s_arm;
    (wrStb && lk && wrData[16]) ##1 (wrStb && lk && !wrData[16] && $stable(wrData[15:0]))
    ##1 (wrStb && lk && wrData[16] && $stable(wrData[15:0])) ##1 (rdStb && lk);
  endsequence
  property p_arm; s_arm |=> lockKeyOut; endproperty
  property p_rise; $rose(lockKeyOut) |-> $past(rdStb && lk) && !rdData[16]; endproperty
  property p_hold; lockKeyOut |=> lockKeyOut; endproperty
  property p_keyRd; rdStb && lk && lockKeyOut |=> rdData[16]; endproperty
  property p_mode; wrStb && addr == 32'h4001_0800 && !lockKeyOut |=> ##1 pinModeOut == $past(wrData, 2); endproperty
  property p_alt; wrStb && addr == 32'h4001_0820 && !lockKeyOut |=> ##1 altFuncOut[31:0] == $past(wrData, 2); endproperty
  property p_unmap; rdStb && addr[31:10] != 22'h10_0042 |=> rdData == 32'h0; endproperty
  property p_usb; $past(rst_n) |-> usbRouted == {2{$past(usbEnable)}}; endproperty
  a_arm: assert property (p_arm) else $error("key not armed");
  a_rise: assert property (p_rise) else $error("key armed without read");
  a_hold: assert property (p_hold) else $error("key cleared");
  a_keyRd: assert property (p_keyRd) else $error("key reads 0");
  a_mode: assert property (p_mode) else $error("mode write lost");
  a_alt: assert property (p_alt) else $error("alt write lost");
  a_unmap: assert property (p_unmap) else $error("foreign read data");
  a_usb: assert property (p_usb) else $error("usb routing");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wrData = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic usbEnable = 1'b0;
  logic [31:0] rdData;
  logic [31:0] pinModeOut;
  logic [63:0] altFuncOut;
  logic [1:0] usbRouted;
  logic lockKeyOut;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  localparam logic [31:0] MODE = 32'h4001_0800;
  localparam logic [31:0] LOCK = 32'h4001_081C;
  localparam logic [31:0] ALT = 32'h4001_0820;
  always #5 mclk = ~mclk;
  gcl_port_lock i_gcl_port_lock (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .usbEnable(usbEnable), .pinModeOut(pinModeOut), .altFuncOut(altFuncOut),
    .usbRouted(usbRouted), .lockKeyOut(lockKeyOut));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write strobe stays up until the next read, so writes can run back to back
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wrStb <= 1'b1;
    rdStb <= 1'b0;
    addr <= a;
    wrData <= d;
    @(posedge mclk);
  endtask
  task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
    wrStb <= 1'b0;
    rdStb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 chk(n, e, rdData);
    @(posedge mclk);
  endtask
  task automatic seq3(input logic [15:0] m0, input logic [15:0] m1);
    wr(LOCK, {16'h0001, m0});
    wr(LOCK, {16'h0000, m1});
    wr(LOCK, {16'h0001, m0});
  endtask
  task automatic t_reset;
    rc("mode", MODE, 32'hFFFF_FFFF);
    rc("lock", LOCK, 32'h0000_0000);
    rc("alt", ALT, 32'h0000_0000);
    wr(32'h4001_0C00, 32'h0000_0000);
    rc("foreign", 32'h4001_0C00, 32'h0000_0000);
    rc("mode", MODE, 32'hFFFF_FFFF);
    $display("t_reset done");
  endtask
  task automatic t_usb;
    usbEnable <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("usbRouted", 32'h3, {30'h0, usbRouted});
    usbEnable <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("usbRouted", 32'h0, {30'h0, usbRouted});
    @(posedge mclk);
    $display("t_usb done");
  endtask
  task automatic t_free;
    wr(LOCK, 32'h0000_FFFF);
    wr(MODE, 32'h1234_5678);
    wr(ALT, 32'hA5A5_A5A5);
    rc("mode", MODE, 32'h1234_5678);
    rc("alt", ALT, 32'hA5A5_A5A5);
    $display("t_free done");
  endtask
  task automatic t_abort;
    seq3(16'h00FF, 16'h00FE);
    rc("lock", LOCK, 32'h0000_00FF);
    wr(LOCK, 32'h0001_00FF);
    rc("lock", LOCK, 32'h0000_00FF);
    wr(LOCK, 32'h0000_00FF);
    wr(LOCK, 32'h0001_00FF);
    rc("lock", LOCK, 32'h0000_00FF);
    chk("lockKeyOut", 32'h0, {31'h0, lockKeyOut});
    $display("t_abort done");
  endtask
  task automatic t_lock;
    seq3(16'h00FF, 16'h00FF);
    rc("lock", LOCK, 32'h0000_00FF);
    chk("lockKeyOut", 32'h1, {31'h0, lockKeyOut});
    seq3(16'h0000, 16'h0000);
    wr(MODE, 32'h0000_0000);
    wr(ALT, 32'h0000_0000);
    rc("lock", LOCK, 32'h0001_00FF);
    rc("mode", MODE, 32'h0000_5678);
    rc("alt", ALT, 32'hA5A5_A5A5);
    chk("pinModeOut", 32'h0000_5678, pinModeOut);
    $display("t_lock done");
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Whole run is under 150 cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_usb;
    t_free;
    t_abort;
    t_lock;
    complete_run;
  end
endmodule
bind gcl_port_lock gcl_lock_monitor #(.PINS(PINS)) i_mon (.mclk(mclk), .rst_n(rst_n), .addr(addr),
  .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .usbEnable(usbEnable),
  .pinModeOut(pinModeOut), .altFuncOut(altFuncOut), .usbRouted(usbRouted), .lockKeyOut(lockKeyOut));
`default_nettype wire
